// ===== inc/pll_lock_consts.svh
// offsets, fields, reset values and counts of the pll lock-detect block
`ifndef PLL_LOCK_CONSTS_SVH
`define PLL_LOCK_CONSTS_SVH

// apb byte offsets
`define LD_OFS_CTRL 12'h000
`define LD_OFS_PINS 12'h004
`define LD_OFS_DIV 12'h008
`define LD_OFS_OUTEN 12'h00c
`define LD_OFS_STATUS 12'h010
`define LD_OFS_IRQ_STAT 12'h014
`define LD_OFS_IRQ_MASK 12'h018

// control register fields
`define LD_CTRL_BACKLASH 1:0
`define LD_CTRL_DLD_OFF 3
`define LD_CTRL_WINDOW 4
`define LD_CTRL_COUNT 6:5
`define LD_CTRL_RESET 32'h0000_0000

// pin register fields
`define LD_PINS_LOCK 5:0
`define LD_PINS_STATUS 13:8
`define LD_PINS_REFERENCE_MONITOR_PIN 20:16
`define LD_PINS_COMP_EN 24
`define LD_PINS_RESET 32'h0000_0000

// divider register fields
`define LD_DIV_R_DLY_EN 0
`define LD_DIV_R_DLY 3:1
`define LD_DIV_N_DLY_EN 4
`define LD_DIV_N_DLY 7:5
`define LD_DIV_PRESC 10:8
`define LD_DIV_B 28:16
`define LD_DIV_RESET 32'h0001_0000
`define LD_DELAY_SPAN_PS 1000

// prescaler codes up to this one are fixed divide, above dual modulus
`define LD_PRESC_FD_MAX 3'h2
`define LD_B_BYPASS 13'h0001

// lock pin control codes
`define LD_PIN_DLD 6'h01
`define LD_PIN_ALD_N 6'h02
`define LD_PIN_ALD_P 6'h03
`define LD_PIN_CSRC 6'h04

// status and reference monitor sources
`define LD_SRC_DLD 6'h01
`define LD_SRC_COMP 6'h02
`define LD_SRC_HIGH 6'h03

// consecutive in-window cycles per count code
`define LD_RUN_CODE0 8'h05
`define LD_RUN_CODE1 8'h10
`define LD_RUN_CODE2 8'h40
`define LD_RUN_CODE3 8'hff

// windows in sys_clk cycles, high range and low range
`define LD_LOCK_THR_HI 8'h03
`define LD_UNLOCK_THR_HI 8'h07
`define LD_LOCK_THR_LO 8'h01
`define LD_UNLOCK_THR_LO 8'h03

// interrupt bits
`define LD_IRQ_GAIN 0
`define LD_IRQ_LOSS 1
`define LD_IRQ_CHARGED 2
`define LD_IRQ_W 3
`define LD_OUTS 12
`define LD_DIFF_MAX 8'hff

`endif

// ===== inc/pll_lock_pkg.sv
// types of the pll lock-detect block
package pll_lock_pkg;
    typedef enum logic [1:0] {MEAS_IDLE, MEAS_WAIT_FB, MEAS_WAIT_REF} meas_state_type;
    typedef struct packed {
        logic valid;
        logic [7:0] diff;
    } pfd_meas_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;
endpackage

// ===== rtl/pfd_edge_meter.sv
// measures rising-edge time difference of the two phase-detector inputs
`include "pll_lock_consts.svh"
module pfd_edge_meter (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ref_pfd,
    input wire logic fb_pfd,
    output pll_lock_pkg::pfd_meas_type meas,
    output logic err_active
);
    import pll_lock_pkg::*;

    logic [2:0] ref_sync_q;
    logic [2:0] fb_sync_q;
    logic ref_rise;
    logic fb_rise;
    meas_state_type state_q;
    logic [7:0] cnt_q;

    // second and third stages feed the edge detector, stage one stays private
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_sync_q <= 3'h0;
            fb_sync_q <= 3'h0;
        end else begin
            ref_sync_q <= {ref_sync_q[1:0], ref_pfd};
            fb_sync_q <= {fb_sync_q[1:0], fb_pfd};
        end
    end

    assign ref_rise = ref_sync_q[1] & ~ref_sync_q[2];
    assign fb_rise = fb_sync_q[1] & ~fb_sync_q[2];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= MEAS_IDLE;
            cnt_q <= 8'h00;
            meas <= '0;
        end else begin
            meas.valid <= 1'b0;
            case (state_q)
                MEAS_IDLE: begin
                    cnt_q <= 8'h01;
                    if (ref_rise && fb_rise) begin
                        meas <= '{valid: 1'b1, diff: 8'h00};
                    end else if (ref_rise) begin
                        state_q <= MEAS_WAIT_FB;
                    end else if (fb_rise) begin
                        state_q <= MEAS_WAIT_REF;
                    end
                end
                MEAS_WAIT_FB, MEAS_WAIT_REF: begin
                    if ((state_q == MEAS_WAIT_FB) ? fb_rise : ref_rise) begin
                        meas <= '{valid: 1'b1, diff: cnt_q};
                        state_q <= MEAS_IDLE;
                    end else if ((state_q == MEAS_WAIT_FB) ? ref_rise : fb_rise) begin
                        // the partner edge never came: count it as a full miss
                        meas <= '{valid: 1'b1, diff: `LD_DIFF_MAX};
                        cnt_q <= 8'h01;
                    end else if (cnt_q != `LD_DIFF_MAX) begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                default: state_q <= MEAS_IDLE;
            endcase
        end
    end

    assign err_active = (state_q != MEAS_IDLE);
endmodule

// ===== rtl/pll_lock_detect.sv
// lock detector of the pll: digital, analog and charged lock, pin routing, apb registers
//
// Notes on behaviour
// - r and n paths get 3-bit delay codes
// - fixed divide with b=1 bypasses a,b
// - lock indicator routable to three pins
// - lock after programmed run of in-window cycles
// - one cycle beyond unlock window drops lock
// - unlock window wider than lock window
// - windows chosen by range, backlash fields, run length by count field
// - two open-drain analog lock output modes
// - current-source mode: source when locked, else short
// - comparator output selectable on status, reference_monitor_pin
// - enable-on-lock outputs follow charged lock indication
// - count code zero needs five cycles
// - disable bit holds lock indicator inactive
//
// The placing of the registers and register access over APB are this design's own decisions.
`include "pll_lock_consts.svh"

module pll_lock_detect (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_pfd,
    input wire logic fb_pfd,
    input wire logic lock_pin_i,
    output logic lock_pin_o,
    output logic lock_pin_oe_n,
    output logic lock_pin_source_on,
    output logic status_pin,
    output logic reference_monitor_pin,
    output logic r_delay_en,
    output logic [2:0] r_delay_code,
    output logic n_delay_en,
    output logic [2:0] n_delay_code,
    output logic fb_ab_bypass,
    output logic [`LD_OUTS-1:0] clk_out_en,
    output logic irq
);
    import pll_lock_pkg::*;

    apb_req_type req;
    pfd_meas_type meas;
    logic err_active;
    logic [31:0] ctrl_q;
    logic [31:0] pins_q;
    logic [31:0] div_q;
    logic [`LD_OUTS-1:0] outen_q;
    logic [`LD_IRQ_W-1:0] irq_stat_q;
    logic [`LD_IRQ_W-1:0] irq_mask_q;
    logic [1:0] comp_sync_q;
    logic digital_lock_indicator_q;
    logic [7:0] run_q;
    logic [7:0] run_target;
    logic [7:0] lock_thr;
    logic [7:0] unlock_thr;
    logic dld_off;
    logic in_window;
    logic out_unlock;
    logic charged_lock_indicator;
    logic charged_q;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [`LD_IRQ_W-1:0] irq_events;
    logic [5:0] lock_mode;
    logic status_pin_q;
    logic reference_monitor_pin_pin_q;

    ////////////////////////////////////////////////////////////////////////
    // pin source multiplexer shared by status and reference monitor pins
    function automatic logic mux_src(input logic [5:0] sel, input logic digital_lock_indicator, input logic comp);
        if (sel == `LD_SRC_DLD) begin
            mux_src = digital_lock_indicator;
        end else if (sel == `LD_SRC_COMP) begin
            mux_src = comp;
        end else if (sel == `LD_SRC_HIGH) begin
            mux_src = 1'b1;
        end else begin
            mux_src = 1'b0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign pready = 1'b1;
    assign wr_en = req.psel & req.penable & req.pwrite;
    assign rd_en = req.psel & req.penable & ~req.pwrite;

    always_comb begin
        addr_ok = 1'b1;
        prdata = 32'h0000_0000;
        if (req.paddr == `LD_OFS_CTRL) begin
            prdata = ctrl_q;
        end else if (req.paddr == `LD_OFS_PINS) begin
            prdata = pins_q;
        end else if (req.paddr == `LD_OFS_DIV) begin
            prdata = div_q;
        end else if (req.paddr == `LD_OFS_OUTEN) begin
            prdata = {20'h00000, outen_q};
        end else if (req.paddr == `LD_OFS_STATUS) begin
            prdata = {{24{1'b0}}, run_q} | {22'h000000, charged_lock_indicator, digital_lock_indicator_q, 8'h00};
        end else if (req.paddr == `LD_OFS_IRQ_STAT) begin
            prdata = {29'h00000000, irq_stat_q};
        end else if (req.paddr == `LD_OFS_IRQ_MASK) begin
            prdata = {29'h00000000, irq_mask_q};
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr = req.psel & req.penable & ~addr_ok;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `LD_CTRL_RESET;
            pins_q <= `LD_PINS_RESET;
            div_q <= `LD_DIV_RESET;
            outen_q <= 12'h000;
            irq_mask_q <= 3'h0;
        end else if (wr_en) begin
            if (req.paddr == `LD_OFS_CTRL) begin
                ctrl_q <= req.pwdata & 32'h0000_007b;
            end else if (req.paddr == `LD_OFS_PINS) begin
                pins_q <= req.pwdata & 32'h011f_3f3f;
            end else if (req.paddr == `LD_OFS_DIV) begin
                div_q <= req.pwdata & 32'h1fff_07ff;
            end else if (req.paddr == `LD_OFS_OUTEN) begin
                outen_q <= req.pwdata[`LD_OUTS-1:0];
            end else if (req.paddr == `LD_OFS_IRQ_MASK) begin
                irq_mask_q <= req.pwdata[`LD_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider path settings
    assign r_delay_en = div_q[`LD_DIV_R_DLY_EN];
    assign r_delay_code = div_q[`LD_DIV_R_DLY];
    assign n_delay_en = div_q[`LD_DIV_N_DLY_EN];
    assign n_delay_code = div_q[`LD_DIV_N_DLY];
    assign fb_ab_bypass = (div_q[`LD_DIV_PRESC] <= `LD_PRESC_FD_MAX) && (div_q[`LD_DIV_B] == `LD_B_BYPASS);

    AST_AB_BYPASS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (div_q[`LD_DIV_B] != `LD_B_BYPASS) |-> !fb_ab_bypass)
        else $error("a/b bypass with b not one");

    ////////////////////////////////////////////////////////////////////////
    // phase measurement and window selection
    pfd_edge_meter u_meter (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ref_pfd(ref_pfd),
        .fb_pfd(fb_pfd),
        .meas(meas),
        .err_active(err_active)
    );

    assign dld_off = ctrl_q[`LD_CTRL_DLD_OFF];

    // backlash width widens both windows alike, keeping unlock above lock
    always_comb begin
        if (ctrl_q[`LD_CTRL_WINDOW]) begin
            lock_thr = `LD_LOCK_THR_LO + {6'h00, ctrl_q[`LD_CTRL_BACKLASH]};
            unlock_thr = `LD_UNLOCK_THR_LO + {6'h00, ctrl_q[`LD_CTRL_BACKLASH]};
        end else begin
            lock_thr = `LD_LOCK_THR_HI + {6'h00, ctrl_q[`LD_CTRL_BACKLASH]};
            unlock_thr = `LD_UNLOCK_THR_HI + {6'h00, ctrl_q[`LD_CTRL_BACKLASH]};
        end
    end

    always_comb begin
        case (ctrl_q[`LD_CTRL_COUNT])
            2'h0: run_target = `LD_RUN_CODE0;
            2'h1: run_target = `LD_RUN_CODE1;
            2'h2: run_target = `LD_RUN_CODE2;
            default: run_target = `LD_RUN_CODE3;
        endcase
    end

    assign in_window = meas.valid && (meas.diff < lock_thr);
    assign out_unlock = meas.valid && (meas.diff > unlock_thr);

    ////////////////////////////////////////////////////////////////////////
    // digital lock indicator
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 8'h00;
            digital_lock_indicator_q <= 1'b0;
        end else if (dld_off) begin
            run_q <= 8'h00;
            digital_lock_indicator_q <= 1'b0;
        end else if (digital_lock_indicator_q) begin
            run_q <= 8'h00;
            // errors between the two windows keep lock, no chatter
            if (out_unlock) begin
                digital_lock_indicator_q <= 1'b0;
            end
        end else if (meas.valid) begin
            if (!in_window) begin
                run_q <= 8'h00;
            end else if (run_q + 8'h01 >= run_target) begin
                run_q <= 8'h00;
                digital_lock_indicator_q <= 1'b1;
            end else begin
                run_q <= run_q + 8'h01;
            end
        end
    end

    AST_LOCK_RUN: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(digital_lock_indicator_q) |-> $past(in_window) && ($past(run_q) + 8'h01 >= $past(run_target)))
        else $error("lock declared without full run");
    AST_FIVE_CYCLES: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ($rose(digital_lock_indicator_q) && $past(ctrl_q[`LD_CTRL_COUNT]) == 2'h0) |-> $past(run_q) == 8'h04)
        else $error("count code zero did not need five cycles");
    AST_UNLOCK_NOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (digital_lock_indicator_q && out_unlock) |=> !digital_lock_indicator_q)
        else $error("lock kept after unlock cycle");
    AST_HYSTERESIS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (digital_lock_indicator_q && !dld_off && !out_unlock) |=> digital_lock_indicator_q)
        else $error("lock dropped inside unlock window");
    AST_RUN_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!digital_lock_indicator_q && meas.valid && meas.diff >= lock_thr) |=> run_q == 8'h00)
        else $error("run kept after out-of-window cycle");
    AST_DLD_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
        dld_off |=> !digital_lock_indicator_q && run_q == 8'h00)
        else $error("lock indicator active while disabled");
    AST_WINDOWS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        unlock_thr > lock_thr)
        else $error("unlock window not wider than lock window");

    ////////////////////////////////////////////////////////////////////////
    // lock pin driver and comparator
    assign lock_mode = pins_q[`LD_PINS_LOCK];

    always_comb begin
        lock_pin_o = 1'b0;
        lock_pin_oe_n = 1'b1;
        lock_pin_source_on = 1'b0;
        if (lock_mode == `LD_PIN_DLD) begin
            lock_pin_o = digital_lock_indicator_q;
            lock_pin_oe_n = 1'b0;
        end else if (lock_mode == `LD_PIN_ALD_N) begin
            lock_pin_oe_n = ~err_active;
        end else if (lock_mode == `LD_PIN_ALD_P) begin
            lock_pin_o = 1'b1;
            lock_pin_oe_n = ~err_active;
        end else if (lock_mode == `LD_PIN_CSRC) begin
            // short at once on loss so the capacitor restarts from zero
            lock_pin_source_on = digital_lock_indicator_q;
            lock_pin_oe_n = digital_lock_indicator_q;
        end else begin
            lock_pin_oe_n = 1'b0;
        end
    end

    AST_CS_SHORT: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lock_mode == `LD_PIN_CSRC) |-> (digital_lock_indicator_q ? (lock_pin_source_on && lock_pin_oe_n)
                                          : (!lock_pin_source_on && !lock_pin_oe_n && !lock_pin_o)))
        else $error("current-source lock pin wrong");
    AST_ALD_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lock_mode == `LD_PIN_ALD_N && err_active) |-> !lock_pin_oe_n && !lock_pin_o)
        else $error("analog lock pulse missing");

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            comp_sync_q <= 2'h0;
        end else begin
            comp_sync_q <= {comp_sync_q[0], lock_pin_i};
        end
    end

    // comparator switched off reads as no charged lock
    assign charged_lock_indicator = pins_q[`LD_PINS_COMP_EN] & comp_sync_q[1];

    // outputs gated by the comparator level after its two-flop synchronizer from lock_pin_i
    genvar gi;
    generate
        for (gi = 0; gi < `LD_OUTS; gi++) begin : g_outen
            assign clk_out_en[gi] = ~outen_q[gi] | charged_lock_indicator;
        end
    endgenerate

    AST_OUT_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (outen_q[0] && !charged_lock_indicator) |-> !clk_out_en[0])
        else $error("output enabled without charged lock");

    ////////////////////////////////////////////////////////////////////////
    // status and reference monitor pins
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_pin_q <= 1'b0;
            reference_monitor_pin_pin_q <= 1'b0;
        end else begin
            status_pin_q <= mux_src(pins_q[`LD_PINS_STATUS], digital_lock_indicator_q,
                                    charged_lock_indicator);
            reference_monitor_pin_pin_q <= mux_src({1'b0, pins_q[`LD_PINS_REFERENCE_MONITOR_PIN]}, digital_lock_indicator_q,
                                    charged_lock_indicator);
        end
    end

    assign status_pin = status_pin_q;
    assign reference_monitor_pin = reference_monitor_pin_pin_q;

    AST_STATUS_COMP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (pins_q[`LD_PINS_STATUS] == `LD_SRC_COMP && $stable(pins_q)) |=> status_pin == $past(charged_lock_indicator))
        else $error("status pin does not follow comparator");

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, read clears, a new event wins over the clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            charged_q <= 1'b0;
        end else begin
            charged_q <= charged_lock_indicator;
        end
    end

    assign irq_events[`LD_IRQ_GAIN] = ~digital_lock_indicator_q & ~dld_off & in_window & (run_q + 8'h01 >= run_target);
    assign irq_events[`LD_IRQ_LOSS] = digital_lock_indicator_q & (out_unlock | dld_off);
    assign irq_events[`LD_IRQ_CHARGED] = charged_lock_indicator & ~charged_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_q <= 3'h0;
        end else if (rd_en && req.paddr == `LD_OFS_IRQ_STAT) begin
            irq_stat_q <= irq_events;
        end else begin
            irq_stat_q <= irq_stat_q | irq_events;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);
endmodule

// ===== dv/pfd_pair_model.sv
// far-side model: divided reference and feedback edges, lock pin capacitor
module pfd_pair_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] lag,
    input wire logic lock_pin_o,
    input wire logic lock_pin_oe_n,
    input wire logic lock_pin_source_on,
    output logic ref_pfd,
    output logic fb_pfd,
    output logic lock_pin_i
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PERIOD = 8'h18;
    localparam logic [7:0] FULL = 8'h1e;
    logic [7:0] phase_q;
    logic [7:0] charge_q;
    ////////////////////////////////////////////////////////////
    // period kept above the widest unlock window
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 8'h00;
        end else if (phase_q == PERIOD - 8'h01) begin
            phase_q <= 8'h00;
        end else begin
            phase_q <= phase_q + 8'h01;
        end
    end
    assign ref_pfd = phase_q < 8'h04;
    assign fb_pfd = (phase_q >= lag) && (phase_q < lag + 8'h04);
    ////////////////////////////////////////////////////////////
    // capacitor on the pin: slow charge, dumped at once when driven
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            charge_q <= 8'h00;
        end else if (!lock_pin_oe_n) begin
            charge_q <= 8'h00;
        end else if (lock_pin_source_on && charge_q < FULL) begin
            charge_q <= charge_q + 8'h01;
        end
    end
    assign lock_pin_i = !lock_pin_oe_n ? lock_pin_o : (charge_q >= FULL);
endmodule

// ===== dv/pll_lock_detect_tb.sv
// self-checking bench of the pll lock detector
`include "pll_lock_consts.svh"
module pll_lock_detect_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, ref_pfd, fb_pfd, lock_pin_i;
    logic lock_pin_o, lock_pin_oe_n, lock_pin_source_on, status_pin, reference_monitor_pin;
    logic r_delay_en, n_delay_en, fb_ab_bypass, irq, err_q;
    logic [2:0] r_delay_code, n_delay_code;
    logic [11:0] paddr, clk_out_en;
    logic [31:0] pwdata, prdata, rd_q;
    logic [7:0] lag;
    int failures, total_checks;
    logic [11:0] row_addr [8] = '{`LD_OFS_CTRL, `LD_OFS_PINS, `LD_OFS_DIV, `LD_OFS_OUTEN,
        `LD_OFS_IRQ_MASK, `LD_OFS_STATUS, 12'h01c, 12'h800};
    logic [31:0] row_rd [8] = '{32'h7b, 32'h011f_3f3f, 32'h1fff_07ff, 32'hfff, 32'h7, 32'h0, 32'h0, 32'h0};
    logic row_err [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
    // the dual-modulus row stands for a setup whose prescaler input meets its limit
    logic [31:0] div_val [3] = '{32'h0001_004b, 32'h0001_0300, 32'h0002_0000};
    logic div_byp [3] = '{1, 0, 0};

    pll_lock_detect dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_pfd(ref_pfd), .fb_pfd(fb_pfd), .lock_pin_i(lock_pin_i),
        .lock_pin_o(lock_pin_o), .lock_pin_oe_n(lock_pin_oe_n), .lock_pin_source_on(lock_pin_source_on),
        .status_pin(status_pin), .reference_monitor_pin(reference_monitor_pin), .r_delay_en(r_delay_en),
        .r_delay_code(r_delay_code), .n_delay_en(n_delay_en), .n_delay_code(n_delay_code),
        .fb_ab_bypass(fb_ab_bypass), .clk_out_en(clk_out_en), .irq(irq));
    pfd_pair_model far (.sys_clk(sys_clk), .reset_n(reset_n), .lag(lag), .lock_pin_o(lock_pin_o),
        .lock_pin_oe_n(lock_pin_oe_n), .lock_pin_source_on(lock_pin_source_on), .ref_pfd(ref_pfd),
        .fb_pfd(fb_pfd), .lock_pin_i(lock_pin_i));

    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb master: holds the request until pready is seen at an edge
    task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        err_q = pslverr;
        if (n >= 50) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_stat(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            rw(1'b0, `LD_OFS_STATUS, 32'h0);
            n++;
        end while ((rd_q & m) !== v && n < 200);
        chk(rd_q & m, v);
        @(negedge sys_clk);
    endtask
    task idle(input int k);
        repeat (k * 24) @(posedge sys_clk);
    endtask
    // analog modes at lag 2: pin driven two cycles per pfd period, so over two periods
    task pulse_chk(input logic [5:0] mode, input logic lvl);
        int lo, hi;
        rw(1'b1, `LD_OFS_PINS, {8'h00, 8'h03, 8'h03, 2'h0, mode});
        lo = 0;
        hi = 0;
        repeat (48) begin
            @(negedge sys_clk);
            if (lock_pin_oe_n === 1'b0 && lock_pin_o === lvl) lo++;
            if (lock_pin_oe_n === 1'b1) hi++;
        end
        chk(lo, 32'd4);
        chk(hi, 32'd44);
        chk({status_pin, reference_monitor_pin}, 2'b11);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
    initial begin
        sys_clk = 0;
        reset_n = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        lag = 8'd12;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rw(1'b1, row_addr[i], 32'hffff_ffff);
            rw(1'b0, row_addr[i], 32'h0);
            chk(rd_q, row_rd[i]);
            chk(err_q, row_err[i]);
        end
        for (int i = 0; i < 3; i++) begin
            rw(1'b1, `LD_OFS_DIV, div_val[i]);
            @(negedge sys_clk);
            chk(fb_ab_bypass, div_byp[i]);
            chk({r_delay_en, r_delay_code, n_delay_en, n_delay_code},
                {div_val[i][0], div_val[i][3:1], div_val[i][4], div_val[i][7:5]});
        end
        // second reset in mid-run brings everything back
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rw(1'b0, `LD_OFS_DIV, 32'h0);
        chk(rd_q, `LD_DIV_RESET);
        rw(1'b0, `LD_OFS_PINS, 32'h0);
        chk(rd_q, `LD_PINS_RESET);
        chk({irq, clk_out_en}, 13'h0fff);
        lag <= 8'd3;
        idle(8);
        wait_stat(32'h1ff, 32'h0);
        rw(1'b1, `LD_OFS_CTRL, 32'h10);
        lag <= 8'd2;
        idle(8);
        wait_stat(32'h1ff, 32'h0);
        rw(1'b1, `LD_OFS_IRQ_MASK, 32'h1);
        rw(1'b1, `LD_OFS_PINS, 32'h0001_0101);
        rw(1'b1, `LD_OFS_CTRL, 32'h0);
        wait_stat(32'h100, 32'h100);
        repeat (2) @(posedge sys_clk);
        chk({lock_pin_o, status_pin, reference_monitor_pin, irq}, 4'b1111);
        rw(1'b0, `LD_OFS_IRQ_STAT, 32'h0);
        chk(rd_q, 32'h1);
        @(negedge sys_clk);
        chk(irq, 1'b0);
        pulse_chk(6'h02, 1'b0);
        pulse_chk(6'h03, 1'b1);
        lag <= 8'd5;
        idle(6);
        wait_stat(32'h100, 32'h100);
        lag <= 8'd12;
        wait_stat(32'h100, 32'h0);
        chk(irq, 1'b0);
        rw(1'b0, `LD_OFS_IRQ_STAT, 32'h0);
        chk(rd_q, 32'h2);
        lag <= 8'd2;
        wait_stat(32'h100, 32'h100);
        rw(1'b1, `LD_OFS_PINS, 32'h0102_0204);
        rw(1'b1, `LD_OFS_OUTEN, 32'h1);
        wait_stat(32'h200, 32'h200);
        repeat (2) @(posedge sys_clk);
        chk({lock_pin_source_on, lock_pin_oe_n, status_pin, reference_monitor_pin}, 4'b1111);
        chk(clk_out_en, 12'hfff);
        lag <= 8'd12;
        wait_stat(32'h300, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk({lock_pin_source_on, lock_pin_oe_n, status_pin, reference_monitor_pin}, 4'b0000);
        chk(clk_out_en, 12'hffe);
        rw(1'b1, `LD_OFS_CTRL, 32'h8);
        lag <= 8'd2;
        idle(8);
        wait_stat(32'h1ff, 32'h0);
        give_verdict();
    end
endmodule
